// [inc/lpmwp_map.vh]
/*
 Offsets, field positions, reset values and frame timing for the
 loader PHY management write port. Assumes a 20 MHz system clock.
*/
`ifndef LPMWP_MAP_VH
`define LPMWP_MAP_VH

// Register offsets on the loader port
`define LPMWP_OFS_DATA 8'ha4
`define LPMWP_OFS_ACCESS 8'ha8

// Field positions
`define LPMWP_DATA_HI 15
`define LPMWP_DATA_LO 0
`define LPMWP_PHYAD_HI 15
`define LPMWP_PHYAD_LO 11
`define LPMWP_REGAD_HI 10
`define LPMWP_REGAD_LO 6
`define LPMWP_MUSTONE_BIT 1

// Reset values
`define LPMWP_DATA_RST 16'h0000
`define LPMWP_ADDR_RST 5'h00

// Management clock: half period in ns and in system cycles
`define LPMWP_CLK_NS 50
`define LPMWP_MDC_HALF_NS 200
`define LPMWP_MDC_HALF_CYC (`LPMWP_MDC_HALF_NS / `LPMWP_CLK_NS)
// Last count of a half period, sized to the three-bit divider
`define LPMWP_MDC_HALF_LAST 3'h3

// Frame: 32 preamble bits then 32 bits of write frame
`define LPMWP_PRE_BITS 7'h20
`define LPMWP_FRAME_BITS 7'h40
`define LPMWP_ST_OP_WR 4'h5
`define LPMWP_TA_WR 2'h2

`endif

// [hw/lpmwp_top.v]
/*
 Loader PHY management write port: two loader-only registers and a
 clause 22 write frame engine driving the internal PHY management pins.
 Each frame is 32 preamble ones followed by a 32-bit write frame, shifted
 MSB first with data changing on the falling management clock edge.
 Assumes loader and host strobes are synchronous to clk_sys_in and last
 one cycle each. Assumes the loader spaces launches by at least one full
 frame, since no completion flag is visible to it; a launch that arrives
 while a frame is running is dropped, though its address fields are kept.
 Assumes the PHYs sample management data on the rising clock edge.
*/
`timescale 1ns/1ps
`include "lpmwp_map.vh"

module lpmwp_top (
   input wire clk_sys_in, // System clock, 20 MHz
   input wire rst_n_in, // Asynchronous reset, active low
   input wire ldr_wr_in, // Loader write strobe
   input wire [7:0] ldr_addr_in, // Loader register offset
   input wire [31:0] ldr_wdata_in, // Loader write data
   input wire host_wr_in, // Host bus write strobe
   input wire host_rd_in, // Host bus read strobe
   input wire [7:0] host_addr_in, // Host bus offset
   output reg [31:0] host_rdata_out, // Host read data, always zero here
   output reg host_refused_out, // Host hit a loader-only register
   output reg mdc_out, // Management clock to PHYs
   output reg mdio_o_out, // Management data out
   output reg mdio_oe_out, // Management data drive enable
   output wire busy_out // Frame in progress
);

   ////////////////////////////////////////////////////////////////////////
   // Registers and state
   localparam ST_IDLE = 2'b01;
   localparam ST_SHIFT = 2'b10;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [15:0] data_r;
   reg [4:0] phyad_r;
   reg [4:0] regad_r;
   reg [31:0] frame_r;
   reg [6:0] bit_cnt_r;
   reg [2:0] half_cnt_r;
   reg launch_r;

   // Offset decode for the host path; loader writes compare each offset on their own
   function hit_port;
      input [7:0] a;
      begin
         hit_port = (a == `LPMWP_OFS_DATA) || (a == `LPMWP_OFS_ACCESS);
      end
   endfunction

   wire wr_data = ldr_wr_in && (ldr_addr_in == `LPMWP_OFS_DATA);
   wire wr_acc = ldr_wr_in && (ldr_addr_in == `LPMWP_OFS_ACCESS);
   // Frame slot decode, needed by the state logic, the data pin and the drive enable
   function last_slot;
      input [6:0] cnt;
      begin
         last_slot = (cnt == (`LPMWP_FRAME_BITS - 7'h01));
      end
   endfunction

   // Divider end and bit boundary; a bit ends on the falling clock edge
   wire half_done = (half_cnt_r == `LPMWP_MDC_HALF_LAST);
   wire bit_end = half_done && mdc_out;
   wire in_idle = (state_r == ST_IDLE);
   // Preamble is done once 32 bit slots have passed
   wire past_preamble = (bit_cnt_r >= (`LPMWP_PRE_BITS - 7'h01));

   assign busy_out = state_r[1];

   ////////////////////////////////////////////////////////////////////////
   // Host side: refused, reads return zero so nothing leaks
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         host_refused_out <= 1'b0;
         host_rdata_out <= 32'h0000_0000;
      end else begin
         host_refused_out <= (host_wr_in || host_rd_in) && hit_port(host_addr_in);
         host_rdata_out <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Loader registers; write-only fields, no readback path
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_r <= `LPMWP_DATA_RST;
         phyad_r <= `LPMWP_ADDR_RST;
         regad_r <= `LPMWP_ADDR_RST;
         launch_r <= 1'b0;
      end else begin
         if (wr_data) begin
            data_r <= ldr_wdata_in[`LPMWP_DATA_HI:`LPMWP_DATA_LO];
         end
         if (wr_acc) begin
            phyad_r <= ldr_wdata_in[`LPMWP_PHYAD_HI:`LPMWP_PHYAD_LO];
            regad_r <= ldr_wdata_in[`LPMWP_REGAD_HI:`LPMWP_REGAD_LO];
         end
         // Bit one is not checked; a launch is taken either way
         launch_r <= wr_acc;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame engine next state; a launch while busy is dropped
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (launch_r) begin
               state_nxt = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (bit_end && last_slot(bit_cnt_r)) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Shifter: preamble of ones, then ST OP PHYAD REGAD TA DATA
   // State register kept apart so the frame timing below reads plainly
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Management clock divider; parked low between frames so idle PHYs see no edges
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         half_cnt_r <= 3'h0;
         mdc_out <= 1'b0;
      end else if (in_idle) begin
         half_cnt_r <= 3'h0;
         mdc_out <= 1'b0;
      end else begin
         half_cnt_r <= half_done ? 3'h0 : (half_cnt_r + 3'h1);
         if (half_done) begin
            mdc_out <= ~mdc_out;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bit slot counter, advanced on each falling management clock edge
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bit_cnt_r <= 7'h00;
      end else if (in_idle) begin
         bit_cnt_r <= 7'h00;
      end else if (bit_end) begin
         bit_cnt_r <= bit_cnt_r + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame word: loaded at launch, shifted once per bit after the preamble
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         frame_r <= 32'h0000_0000;
      end else if (in_idle) begin
         if (launch_r) begin
            // Write-only opcode; 16-bit data field
            frame_r <= {`LPMWP_ST_OP_WR, phyad_r, regad_r, `LPMWP_TA_WR, data_r};
         end
      end else if (bit_end && past_preamble) begin
         frame_r <= {frame_r[30:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data pin; changes on the falling edge so the PHY samples it stable
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mdio_o_out <= 1'b1;
      end else if (in_idle) begin
         mdio_o_out <= 1'b1;
      end else if (bit_end) begin
         if (last_slot(bit_cnt_r)) begin
            // Back to the idle level once the last data bit is taken
            mdio_o_out <= 1'b1;
         end else if (past_preamble) begin
            mdio_o_out <= frame_r[31];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Drive enable: up from the launch cycle, down after the last bit slot
   // Preamble is driven high too, so no pull-up is relied on for it
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mdio_oe_out <= 1'b0;
      end else if (in_idle) begin
         mdio_oe_out <= launch_r;
      end else if (bit_end && last_slot(bit_cnt_r)) begin
         mdio_oe_out <= 1'b0;
      end
   end

endmodule

// [bench/lpmwp_phy_model.sv]
/* PHY side model: collects the management bits sent by the port.
 Assumes mdc_in rests low whenever oe_in is low. */
`timescale 1ns/1ps
module lpmwp_phy_model (
   input wire mdc_in, // Mgmt clock
   input wire mdio_in, // Mgmt data
   input wire oe_in, // Port drive enable
   input wire clr_in, // Clear capture
   output reg [63:0] frame_out, // Bits, first in at top
   output reg [6:0] bits_out // Bits taken
);
// PHY samples on the rising clock; write only, so it never drives back
always @(posedge mdc_in or posedge clr_in) begin
   if (clr_in) begin
      frame_out <= 64'h0;
      bits_out <= 7'h00;
   end else if (oe_in) begin
      frame_out <= {frame_out[62:0], mdio_in};
      bits_out <= bits_out + 7'h01;
   end
end
endmodule

// [bench/lpmwp_monitor.sv]
/* Port checker for lpmwp_top.
 Assumes it is bound to every instance of the top. */
`timescale 1ns/1ps
module lpmwp_monitor (
   input wire clk_sys_in, // Clk
   input wire rst_n_in, // Rst
   input wire ldr_wr_in, // Ld wr
   input wire [7:0] ldr_addr_in, // Ld ofs
   input wire host_wr_in, // H wr
   input wire host_rd_in, // H rd
   input wire [7:0] host_addr_in, // H ofs
   input wire [31:0] host_rdata_out, // H data
   input wire host_refused_out, // H refuse
   input wire mdc_out, // Mgmt clock
   input wire mdio_o_out, // Mgmt data
   input wire mdio_oe_out, // Drive enable
   input wire busy_out // Busy
);
reg [9:0] cnt_r;
default clocking @(posedge clk_sys_in); endclocking
default disable iff (!rst_n_in);
// Busy length, cleared when idle so each frame counts alone
always @(posedge clk_sys_in or negedge rst_n_in)
   if (!rst_n_in) cnt_r <= 10'h000;
   else cnt_r <= busy_out ? cnt_r + 10'h001 : 10'h000;
sequence mdc_high_s;
   mdc_out [*4] ##1 !mdc_out;
endsequence
a_host_refused: assert property ((host_rd_in | host_wr_in) && host_addr_in[7:4] == 4'ha &&
   (host_addr_in[3:0] == 4'h4 || host_addr_in[3:0] == 4'h8) |=> host_refused_out) else $error("host not refused");
a_rdata_zero: assert property (host_rd_in |=> host_rdata_out == 32'h0) else $error("host read leak");
a_launch_busy: assert property (ldr_wr_in && ldr_addr_in == 8'ha8 && !busy_out |-> ##[2:3] busy_out)
   else $error("no launch");
a_frame_len: assert property ($fell(busy_out) |-> cnt_r > 10'd509 && cnt_r < 10'd515)
   else $error("frame length");
a_mdc_half: assert property ($rose(mdc_out) |-> mdc_high_s) else $error("mdc half period");
a_mdio_setup: assert property ($rose(mdc_out) |-> $stable(mdio_o_out)) else $error("data moved");
a_oe_in_frame: assert property (mdio_oe_out |-> busy_out) else $error("drive outside frame");
a_idle_lines: assert property (!busy_out && !$past(busy_out) |-> !mdc_out && !mdio_oe_out)
   else $error("idle lines");
endmodule
bind lpmwp_top lpmwp_monitor lpmwp_monitor_inst (.*);

// [bench/lpmwp_top_test.sv]
/* Bench for lpmwp_top: host refusal and PHY write frames.
 Assumes the PHY model and the map header on the include path. */
`timescale 1ns/1ps
`include "lpmwp_map.vh"
module lpmwp_top_test;
reg clk_sys_in = 1'b0;
reg rst_n_in = 1'b0;
reg ldr_wr_in = 1'b0;
reg host_wr_in = 1'b0;
reg host_rd_in = 1'b0;
reg clr = 1'b0;
reg [7:0] ldr_addr_in = 8'h00;
reg [7:0] host_addr_in = 8'h00;
reg [31:0] ldr_wdata_in = 32'h0;
reg [25:0] v;
wire [31:0] host_rdata_out;
wire host_refused_out, mdc_out, mdio_o_out, mdio_oe_out, busy_out;
wire [63:0] frame;
wire [6:0] nbits;
integer fail_count = 0;
integer tests_run = 0;
integer cyc = 0;
integer i;
integer w;
lpmwp_top lpmwp_top_inst (.*);
lpmwp_phy_model lpmwp_phy_model_inst (.mdc_in(mdc_out), .mdio_in(mdio_o_out), .oe_in(mdio_oe_out),
   .clr_in(clr), .frame_out(frame), .bits_out(nbits));
// Clock and hang guard; three frames need about 1600 cycles
initial forever #25 clk_sys_in = ~clk_sys_in;
always @(posedge clk_sys_in) begin
   cyc = cyc + 1;
   if (cyc == 4000) begin
      fail_count = fail_count + 1;
      finish_test;
   end
end
task check(input [63:0] got, input [63:0] want);
   begin
      tests_run = tests_run + 1;
      if (got !== want) begin
         fail_count = fail_count + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, want);
      end
   end
endtask
task ldr_write(input [7:0] a, input [31:0] d);
   begin
      @(posedge clk_sys_in) #5;
      ldr_wr_in = 1'b1;
      ldr_addr_in = a;
      ldr_wdata_in = d;
      @(posedge clk_sys_in) #5;
      ldr_wr_in = 1'b0;
   end
endtask
task host_acc(input wr, input [7:0] a, input refused);
   begin
      @(posedge clk_sys_in) #5;
      host_wr_in = wr;
      host_rd_in = !wr;
      host_addr_in = a;
      @(posedge clk_sys_in) #5;
      host_wr_in = 1'b0;
      host_rd_in = 1'b0;
      check(host_refused_out, refused);
      check(host_rdata_out, 0);
   end
endtask
task wait_busy(input val);
   begin
      w = 0;
      while (busy_out !== val && w < 600) begin
         @(posedge clk_sys_in) #5;
         w = w + 1;
      end
      check(busy_out, val);
   end
endtask
task finish_test;
   begin
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   end
endtask
// Host refusal, then one frame per field corner; upper data bits must not leak
initial begin
   repeat (3) @(posedge clk_sys_in);
   #5 rst_n_in = 1'b1;
   for (i = 0; i < 4; i = i + 1) host_acc(i[0], i < 2 ? 8'ha4 : 8'ha8, 1'b1);
   host_acc(1'b0, 8'h10, 1'b0);
   for (i = 0; i < 3; i = i + 1) begin
      v = i == 0 ? 26'h3e0ffff : i == 1 ? 26'h01f0000 : 26'h2aaa5c3;
      // Clear pulse held over one edge so each capture starts from zero
      clr = 1'b1;
      @(posedge clk_sys_in) #5;
      clr = 1'b0;
      ldr_write(`LPMWP_OFS_DATA, {16'hffff, v[15:0]});
      ldr_write(`LPMWP_OFS_ACCESS, {16'h0, v[25:16], 6'h02});
      wait_busy(1'b1);
      if (i == 1) ldr_write(`LPMWP_OFS_ACCESS, {16'h0, v[25:16], 6'h02});
      wait_busy(1'b0);
      check(frame, {32'hffffffff, 4'h5, v[25:16], 2'h2, v[15:0]});
      check(nbits, 64);
      repeat (4) @(posedge clk_sys_in) #5;
      check(busy_out, 0);
   end
   finish_test;
end
endmodule
